// file: rtl/pmt_apb_decode.sv
// APB access decode: write strobes and read multiplexer
`timescale 1ns/100ps
`include "pmt_map.svh"
module pmt_apb_decode (
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [7:0] count,
   input wire logic [7:0] period,
   input wire logic [2:0] ctrl,
   input wire logic status,
   input wire logic enable,
   output logic wr_count,
   output logic wr_period,
   output logic wr_ctrl,
   output logic wr_clear,
   output logic wr_enable,
   output logic [31:0] rdata,
   output logic slverr
);
   logic acc;
   logic wr;
   logic hit;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign wr_count = wr && (paddr == `PMT_OFF_COUNT);
   assign wr_period = wr && (paddr == `PMT_OFF_PERIOD);
   assign wr_ctrl = wr && (paddr == `PMT_OFF_CTRL);
   assign wr_clear = wr && (paddr == `PMT_OFF_CLEAR);
   assign wr_enable = wr && (paddr == `PMT_OFF_ENABLE);

   always_comb begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         `PMT_OFF_COUNT: rdata = {24'h000000, count};
         `PMT_OFF_PERIOD: rdata = {24'h000000, period};
         `PMT_OFF_CTRL: rdata = {29'h0000_0000, ctrl};
         `PMT_OFF_STATUS: rdata = {31'h0000_0000, status};
         `PMT_OFF_CLEAR: rdata = 32'h0000_0000;
         `PMT_OFF_ENABLE: rdata = {31'h0000_0000, enable};
         default: hit = 1'b0;
      endcase
      slverr = acc && !hit;
   end
endmodule : pmt_apb_decode

// file: rtl/pmt_map.svh
// Register offsets, field positions and reset values of the period match timer
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH
`define PMT_OFF_COUNT 12'h000
`define PMT_OFF_PERIOD 12'h004
`define PMT_OFF_CTRL 12'h008
`define PMT_OFF_STATUS 12'h00c
`define PMT_OFF_CLEAR 12'h010
`define PMT_OFF_ENABLE 12'h014
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CTRL_RST 3'h0
`define PMT_RUN_BIT 2
`define PMT_PS_LSB 0
`define PMT_PS_MSB 1
`define PMT_MATCH_BIT 0
`define PMT_LAST_DIV1 4'h0
`define PMT_LAST_DIV4 4'h3
`define PMT_LAST_DIV8 4'h7
`define PMT_LAST_DIV16 4'hf
`endif

// file: rtl/pmt_pkg.sv
// Types of the period match timer
package pmt_pkg;
   typedef enum logic [1:0] {
      PMT_DIV1 = 2'b00,
      PMT_DIV4 = 2'b01,
      PMT_DIV8 = 2'b10,
      PMT_DIV16 = 2'b11
   } pmt_div_e;
endpackage : pmt_pkg

// file: rtl/pmt_prescaler.sv
// Selectable clock prescaler producing one tick per division period
`timescale 1ns/100ps
`include "pmt_map.svh"
module pmt_prescaler (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic clr,
   input wire logic [1:0] sel,
   output logic tick
);
   logic [3:0] cnt_q;
   logic [3:0] last;

   always_comb begin
      case (pmt_pkg::pmt_div_e'(sel))
         pmt_pkg::PMT_DIV1: last = `PMT_LAST_DIV1;
         pmt_pkg::PMT_DIV4: last = `PMT_LAST_DIV4;
         pmt_pkg::PMT_DIV8: last = `PMT_LAST_DIV8;
         pmt_pkg::PMT_DIV16: last = `PMT_LAST_DIV16;
         default: last = `PMT_LAST_DIV1;
      endcase
   end

   assign tick = run && !clr && (cnt_q == last);

   always_ff @(posedge mclk) begin
      if (sys_rst || clr) begin
         cnt_q <= 4'h0;
      end else if (run) begin
         cnt_q <= (cnt_q == last) ? 4'h0 : cnt_q + 4'h1;
      end
   end
endmodule : pmt_prescaler

// file: rtl/pmt_top.sv
// Period match timer with APB register access and match interrupt
//
// Contract
// - 8-bit counter advances once per prescaler output pulse from system clock.
// - Count up from 00h; on equality with period, next increment returns 00h.
// - Counter equal to period at a prescaler output pulse sets the match interrupt flag.
// - Counter and period registers are readable and writable at any time.
// - Any reset loads counter with 00h and period with FFh.
// - Timer counts only while control bit 2 (run) is one.
// - Prescale field bits 1:0 selects divide by 1, 4, 8 or 16.
// - Prescaler cleared on counter write, control write and reset.
// - Control register write leaves the counter value unchanged.
`timescale 1ns/100ps
`include "pmt_map.svh"
module pmt_top (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] count_q;
   logic [7:0] period_q;
   logic [2:0] ctrl_q;
   logic flag_q;
   logic ien_q;
   logic wr_count;
   logic wr_period;
   logic wr_ctrl;
   logic wr_clear;
   logic wr_enable;
   logic lane0;
   logic tick;
   logic match;
   logic run;
   logic ps_clr;
   logic [3:0] gap_q;
   logic [3:0] exp_last;

   assign lane0 = pstrb[0];
   assign run = ctrl_q[`PMT_RUN_BIT];
   assign match = (count_q == period_q);
   assign pready = 1'b1;
   assign ps_clr = (wr_count || wr_ctrl) && lane0;

   pmt_apb_decode u_dec (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .count(count_q),
      .period(period_q),
      .ctrl(ctrl_q),
      .status(flag_q),
      .enable(ien_q),
      .wr_count(wr_count),
      .wr_period(wr_period),
      .wr_ctrl(wr_ctrl),
      .wr_clear(wr_clear),
      .wr_enable(wr_enable),
      .rdata(prdata),
      .slverr(pslverr)
   );

   // Prescaler restarts on counter or control writes
   pmt_prescaler u_ps (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(run),
      .clr(ps_clr),
      .sel(ctrl_q[`PMT_PS_MSB:`PMT_PS_LSB]),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_q <= `PMT_COUNT_RST;
      end else if (wr_count && lane0) begin
         count_q <= pwdata[7:0];
      end else if (tick) begin
         count_q <= match ? 8'h00 : count_q + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         period_q <= `PMT_PERIOD_RST;
      end else if (wr_period && lane0) begin
         period_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_q <= `PMT_CTRL_RST;
      end else if (wr_ctrl && lane0) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match flag set on the wrapping increment; set beats clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
      end else if (tick && match) begin
         flag_q <= 1'b1;
      end else if (wr_clear && lane0 && pwdata[`PMT_MATCH_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ien_q <= 1'b0;
      end else if (wr_enable && lane0) begin
         ien_q <= pwdata[`PMT_MATCH_BIT];
      end
   end

   assign irq = flag_q && ien_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reference prescaler phase for the spacing checks
   always_ff @(posedge mclk) begin
      if (sys_rst || ps_clr || tick) begin
         gap_q <= 4'h0;
      end else if (run) begin
         gap_q <= gap_q + 4'h1;
      end
   end

   always_comb begin
      case (ctrl_q[`PMT_PS_MSB:`PMT_PS_LSB])
         2'b00: exp_last = `PMT_LAST_DIV1;
         2'b01: exp_last = `PMT_LAST_DIV4;
         2'b10: exp_last = `PMT_LAST_DIV8;
         2'b11: exp_last = `PMT_LAST_DIV16;
         default: exp_last = `PMT_LAST_DIV1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset
   a_reset_values: assert property (
      @(posedge mclk)
      sys_rst
      |=> count_q == 8'h00 && period_q == 8'hff)
      else $error("reset values wrong");

   a_reset_irq: assert property (
      @(posedge mclk)
      sys_rst
      |=> !flag_q && !ien_q && !irq && ctrl_q == `PMT_CTRL_RST)
      else $error("interrupt state not reset");

   // Counting and prescaling
   a_count_wrap: assert property (
      @(posedge mclk) disable iff (sys_rst)
      tick && match && !(wr_count && lane0)
      |=> count_q == 8'h00)
      else $error("counter did not wrap");

   a_count_step: assert property (
      @(posedge mclk) disable iff (sys_rst)
      tick && !match && !(wr_count && lane0)
      |=> count_q == $past(count_q) + 8'h01)
      else $error("counter did not advance");

   a_count_hold: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !tick && !(wr_count && lane0)
      |=> $stable(count_q))
      else $error("counter moved without a tick");

   a_stop_hold: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run && !(wr_count && lane0)
      |=> count_q == $past(count_q))
      else $error("counter moved while stopped");

   a_tick_run: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run
      |-> !tick)
      else $error("tick while stopped");

   a_tick_spacing: assert property (
      @(posedge mclk) disable iff (sys_rst)
      run && !ps_clr
      |-> tick == (gap_q == exp_last))
      else $error("prescaler tick spacing wrong");

   a_div_four: assert property (
      @(posedge mclk) disable iff (sys_rst)
      tick && run && ctrl_q[1:0] == 2'b01 && !wr_ctrl && !wr_count ##1 (!wr_ctrl && !wr_count)[*3]
      |-> !$past(tick, 1) && !$past(tick, 2))
      else $error("divide by four spacing wrong");

   a_tick_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      ps_clr
      |-> !tick)
      else $error("tick during prescaler clear");

   a_ps_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_count && lane0 && ctrl_q[1:0] == 2'b11 && run ##1 !wr_ctrl && !wr_count
      |-> !tick)
      else $error("prescaler not cleared");

   a_ctrl_keep: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_ctrl && lane0
      |=> count_q == $past(count_q))
      else $error("control write changed counter");

   // Register access
   a_rw_count: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_count && lane0
      |=> count_q == $past(pwdata[7:0]))
      else $error("counter write lost");

   a_lane_ignore: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_count && !lane0 && !tick
      |=> $stable(count_q))
      else $error("masked counter write landed");

   a_rw_period: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_period && lane0
      |=> period_q == $past(pwdata[7:0]))
      else $error("period write lost");

   a_period_hold: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(wr_period && lane0)
      |=> $stable(period_q))
      else $error("period changed without a write");

   a_ctrl_write: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_ctrl && lane0
      |=> ctrl_q == $past(pwdata[2:0]))
      else $error("control write lost");

   a_ctrl_hold: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(wr_ctrl && lane0)
      |=> $stable(ctrl_q))
      else $error("control changed without a write");

   a_read_count: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !pwrite && paddr == `PMT_OFF_COUNT
      |-> prdata == {24'h000000, count_q})
      else $error("counter read wrong");

   a_read_period: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !pwrite && paddr == `PMT_OFF_PERIOD
      |-> prdata == {24'h000000, period_q})
      else $error("period read wrong");

   a_read_ctrl: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !pwrite && paddr == `PMT_OFF_CTRL
      |-> prdata == {29'h0000_0000, ctrl_q})
      else $error("control read wrong");

   a_read_status: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !pwrite && paddr == `PMT_OFF_STATUS
      |-> prdata == {31'h0000_0000, flag_q})
      else $error("status read wrong");

   a_unmapped_err: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !(paddr inside {`PMT_OFF_COUNT, `PMT_OFF_PERIOD, `PMT_OFF_CTRL,
         `PMT_OFF_STATUS, `PMT_OFF_CLEAR, `PMT_OFF_ENABLE})
      |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_mapped_ok: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && (paddr inside {`PMT_OFF_COUNT, `PMT_OFF_PERIOD, `PMT_OFF_CTRL,
         `PMT_OFF_STATUS, `PMT_OFF_CLEAR, `PMT_OFF_ENABLE})
      |-> !pslverr)
      else $error("mapped access refused");

   // Match flag and interrupt
   a_flag_set: assert property (
      @(posedge mclk) disable iff (sys_rst)
      tick && match
      |=> flag_q)
      else $error("match flag not set");

   a_flag_cause: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !flag_q && !(tick && match)
      |=> !flag_q)
      else $error("match flag set without a wrap");

   a_flag_sticky: assert property (
      @(posedge mclk) disable iff (sys_rst)
      flag_q && !(wr_clear && pwdata[0] && lane0)
      |=> flag_q)
      else $error("flag dropped on its own");

   a_flag_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_clear && lane0 && pwdata[`PMT_MATCH_BIT] && !(tick && match)
      |=> !flag_q)
      else $error("flag not cleared");

   a_irq_level: assert property (
      @(posedge mclk) disable iff (sys_rst)
      tick && match && ien_q && !(wr_enable && lane0)
      |=> irq)
      else $error("interrupt not raised on match");

   a_irq_enable: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_enable && lane0 && !pwdata[`PMT_MATCH_BIT]
      |=> !irq)
      else $error("interrupt high while disabled");

   a_enable_write: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_enable && lane0
      |=> ien_q == $past(pwdata[`PMT_MATCH_BIT]))
      else $error("enable write lost");

   a_clear_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      psel && penable && !pwrite && paddr == `PMT_OFF_CLEAR
      |-> prdata == 32'h0000_0000)
      else $error("clear register read not zero");
endmodule : pmt_top

// file: tb/tb_period_match_timer.sv
// Self-checking bench of the period match timer against a cycle model
`timescale 1ns/100ps
module tb_period_match_timer;
logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic [3:0] pstrb;
int fails, num_checks, cyc, seed, i, a, r;
int m_cnt, m_per, m_ctl, m_flag, m_en, m_pc, tk, dv, w;

pmt_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq));

initial begin
   mclk = 0;
   forever #12.5 mclk = ~mclk;
end

////////////////////////////////////////
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
   num_checks++;
   if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
   end
endtask : chk

task end_of_test();
   $display("checks %0d mismatches %0d", num_checks, fails);
   if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
   else $display("CHECKS NOT OK");
   $finish;
endtask : end_of_test

function int ex(int ad);
   case (ad)
      0: return m_cnt;
      4: return m_per;
      8: return m_ctl;
      12: return m_flag;
      20: return m_en;
      default: return 0;
   endcase
endfunction : ex

// Setup, then access held until pready at a rising edge
task apb(input int wr, input int ad, input logic [31:0] d, input logic [3:0] s);
   @(posedge mclk);
   psel <= 1;
   penable <= 0;
   pwrite <= wr[0];
   paddr <= ad[11:0];
   pwdata <= d;
   pstrb <= s;
   @(posedge mclk);
   penable <= 1;
   @(posedge mclk);
   while (pready !== 1'b1) @(posedge mclk);
   if (wr == 0) chk("prdata", prdata, ex(ad));
   chk("pslverr", {31'h0, pslverr}, ad > 20);
   psel <= 0;
   penable <= 0;
endtask : apb

////////////////////////////////////////
// Cycle model of counter, prescaler, flag and enable
always @(posedge mclk) begin
   w = psel && penable && pwrite && pstrb[0];
   dv = (m_ctl & 3) == 0 ? 1 : 2 << (m_ctl & 3);
   tk = 0;
   if (sys_rst) begin
      m_cnt <= 0;
      m_per <= 255;
      m_ctl <= 0;
      m_flag <= 0;
      m_en <= 0;
      m_pc <= 0;
   end else begin
      if (w && (paddr == 0 || paddr == 8)) m_pc <= 0;
      else if (m_ctl & 4) begin
         tk = m_pc == dv - 1;
         m_pc <= tk ? 0 : m_pc + 1;
      end
      if (tk && m_cnt == m_per) m_flag <= 1;
      else if (w && paddr == 16 && pwdata[0]) m_flag <= 0;
      if (w && paddr == 0) m_cnt <= pwdata & 255;
      else if (tk) m_cnt <= m_cnt == m_per ? 0 : (m_cnt + 1) & 255;
      if (w && paddr == 4) m_per <= pwdata & 255;
      if (w && paddr == 8) m_ctl <= pwdata & 7;
      if (w && paddr == 20) m_en <= pwdata & 1;
   end
   cyc++;
   if (cyc == 20000) begin
      fails++;
      end_of_test();
   end
end

always @(negedge mclk) begin
   if (!sys_rst && cyc > 5) chk("irq", {31'h0, irq}, m_flag & m_en);
end

////////////////////////////////////////
initial begin
   seed = 67;
   fails = 0;
   num_checks = 0;
   cyc = 0;
   sys_rst = 1;
   psel = 0;
   penable = 0;
   pwrite = 0;
   paddr = 0;
   pwdata = 0;
   pstrb = 0;
   repeat (4) @(posedge mclk);
   sys_rst <= 0;
   for (a = 0; a < 32; a += 4) apb(0, a, 0, 0);
   $display("test reset values done");
   for (i = 0; i < 4; i++) begin
      apb(1, 4, $random(seed) & 7, 4'hf);
      apb(1, 20, 1, 4'hf);
      apb(1, 0, 0, 4'hf);
      apb(1, 8, 4 | i, 4'hf);
      repeat (40) @(posedge mclk);
      apb(0, 0, 0, 0);
      apb(0, 12, 0, 0);
      apb(1, 16, 1, 4'hf);
      apb(0, 12, 0, 0);
   end
   apb(1, 4, 32'h55, 4'h0);
   apb(0, 4, 0, 0);
   $display("test prescale and wrap done");
   for (i = 0; i < 80; i++) begin
      a = ($random(seed) & 7) * 4;
      r = $random(seed);
      apb(r & 1, a, $random(seed), (r & 1) && (r & 6) ? 4'hf : 4'h0);
      repeat ((r >> 4) & 15) @(posedge mclk);
   end
   $display("test random traffic done");
   @(posedge mclk);
   sys_rst <= 1;
   repeat (4) @(posedge mclk);
   sys_rst <= 0;
   for (a = 0; a < 24; a += 4) apb(0, a, 0, 0);
   $display("test second reset done");
   end_of_test();
end
endmodule : tb_period_match_timer
